//--- hdl/sts_seq_regs.vh
// Constants for the sensor travel sequencer
`ifndef STS_SEQ_REGS_VH
`define STS_SEQ_REGS_VH
// Clock period in ns
`define STS_CLK_NS          4
// Least valid request pulse width in ms
`define STS_MIN_PULSE_MS    200
// Cycles per ms at 250 MHz
`define STS_CYC_PER_MS      250000
// Default dwell period at the retreat height in ms
`define STS_DWELL_MS        10000
// Default internal interval timer period in ms
`define STS_INTERVAL_MS     600000
// Profile speed multiplier over control speed
`define STS_PROF_MULT       5
// Position, speed and output value widths
`define STS_POS_W           16
`define STS_SPD_W           16
`define STS_OUT_W           16
// Sequencer states
`define STS_ST_MEAS         4'h0
`define STS_ST_RET_OUT      4'h1
`define STS_ST_RET_DWELL    4'h2
`define STS_ST_RET_HOLD     4'h3
`define STS_ST_RET_BACK     4'h4
`define STS_ST_PRF_UP       4'h5
`define STS_ST_PRF_SCAN     4'h6
`define STS_ST_PRF_BACK     4'h7
`endif

//--- hdl/sts_seq_filt.v
// Request input filter with minimum pulse width and rising-edge detection
`timescale 1ns/1ps
module sts_seq_filt #(
    parameter MIN_CYC = 50000000,      // Least pulse width in cycles
    parameter CNT_W   = 32             // Counter width
) (
    input  wire clk_i,                 // Clock
    input  wire rst_n,                 // Synchronised reset, active low
    input  wire req_i,                 // Raw request level, high at 24 V
    output reg  level_o,               // Filtered level
    output reg  rise_o                 // One-cycle pulse on accepted rise
);
    reg [CNT_W-1:0] cnt_r;
    // Count how long the input has held high; drop on any gap
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r   <= {CNT_W{1'b0}};
            level_o <= 1'b0;
            rise_o  <= 1'b0;
        end else begin
            rise_o <= 1'b0;
            if (!req_i) begin
                cnt_r   <= {CNT_W{1'b0}};
                level_o <= 1'b0;
            end else if (!level_o) begin
                if (cnt_r >= MIN_CYC[CNT_W-1:0] - 1'b1) begin
                    level_o <= 1'b1;
                    rise_o  <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end
endmodule

//--- hdl/sts_seq_mover.v
// Step generator moving a position toward a target at a given rate
`timescale 1ns/1ps
module sts_seq_mover #(
    parameter POS_W = 16,              // Position width
    parameter SPD_W = 16               // Step interval width
) (
    input  wire             clk_i,     // Clock
    input  wire             rst_n,     // Synchronised reset, active low
    input  wire             run_i,     // Movement allowed
    input  wire [POS_W-1:0] target_i,  // Target position
    input  wire [SPD_W-1:0] intv_i,    // Cycles between steps, 0 treated as 1
    output reg  [POS_W-1:0] pos_o,     // Current position
    output reg              step_o,    // Step pulse
    output reg              dir_o,     // 1 moves down (position rises)
    output wire             at_o       // Position equals target
);
    reg [SPD_W-1:0] div_r;
    assign at_o = (pos_o == target_i);
    // Divider produces one step enable per interval
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            div_r  <= {SPD_W{1'b0}};
            pos_o  <= {POS_W{1'b0}};
            step_o <= 1'b0;
            dir_o  <= 1'b0;
        end else begin
            step_o <= 1'b0;
            if (!run_i || at_o) begin
                div_r <= {SPD_W{1'b0}};
            end else if (div_r + 1'b1 >= intv_i) begin
                div_r  <= {SPD_W{1'b0}};
                step_o <= 1'b1;
                dir_o  <= (target_i > pos_o);
                if (target_i > pos_o)
                    pos_o <= pos_o + 1'b1;
                else
                    pos_o <= pos_o - 1'b1;
            end else begin
                div_r <= div_r + 1'b1;
            end
        end
    end
endmodule

//--- hdl/sts_seq.v
// Sensor travel sequencer: retreat and profile excursions
`timescale 1ns/1ps
`include "sts_seq_regs.vh"
// How it works
// - Inactive retreat input leaves the device measuring, no excursion.
// - Retreat input counts as asserted when high (24 V level).
// - Retreat pulse of 200 ms or more moves to retreat height and dwells.
// - Request still high after dwell keeps sensor at retreat height.
// - After dwell sensor returns to prior position and measures again.
// - Outward and return retreat travel use fast speed.
// - Measurement suspended, depth and solids outputs held during retreat.
// - Profile input high for 200 ms or more starts a profile scan.
// - One profile request gives exactly one scan, top to bottom.
// - Scan begins with fast travel to the highest calibrated point.
// - Descent records at five times the control speed, slowed by the filter time setting.
// - During scan depth drives output one, solids optionally output two.
// - After scan sensor returns fast to the prior measuring position.
// - Scan speed depends on the signal filter time setting.
// - Excursions start from external inputs or the internal interval timer.
// - Hold status output asserted whenever measurement is frozen.
module sts_seq #(
    parameter POS_W       = `STS_POS_W,                        // Position width
    parameter SPD_W       = `STS_SPD_W,                        // Speed interval width
    parameter OUT_W       = `STS_OUT_W,                        // Output value width
    parameter MIN_CYC     = `STS_MIN_PULSE_MS * `STS_CYC_PER_MS, // Least pulse, cycles
    parameter DWELL_CYC   = `STS_DWELL_MS * `STS_CYC_PER_MS,   // Dwell default, cycles
    parameter TICK_CYC    = `STS_CYC_PER_MS                    // Cycles per interval tick
) (
    input  wire             clk_i,         // Clock, 250 MHz
    input  wire             rstn_i,        // Reset, active low, asynchronous
    input  wire             retreat_req_i, // Retreat request, high at 24 V
    input  wire             profile_req_i, // Profile request, high at 24 V
    input  wire             auto_mode_i,   // Automatic measuring mode
    input  wire             timer_en_i,    // Internal interval timer enable
    input  wire             timer_prof_i,  // Timer launches profile (else retreat)
    input  wire [31:0]      interval_ms_i, // Interval timer period in ms
    input  wire [31:0]      dwell_ms_i,    // Retreat dwell in ms, 0 uses default
    input  wire [POS_W-1:0] retreat_pos_i, // Retreat height position
    input  wire [POS_W-1:0] top_pos_i,     // Highest calibrated point
    input  wire [POS_W-1:0] bottom_pos_i,  // Lowest calibrated point
    input  wire [POS_W-1:0] meas_pos_i,    // Measuring target in normal mode
    input  wire [SPD_W-1:0] fast_intv_i,   // Fast speed step interval
    input  wire [SPD_W-1:0] ctrl_intv_i,   // Control speed step interval
    input  wire [3:0]       filt_time_i,   // Signal filter time setting
    input  wire [OUT_W-1:0] depth_i,       // Live depth value
    input  wire [OUT_W-1:0] solids_i,      // Live solids value
    input  wire             solids_en_i,   // Solids on output two during scan
    output reg  [OUT_W-1:0] cur1_o,        // Current output one (depth)
    output reg  [OUT_W-1:0] cur2_o,        // Current output two (solids)
    output reg              hold_o,        // Measurement frozen
    output reg              busy_o,        // Excursion running
    output reg              profiling_o,   // Profile descent active
    output wire [POS_W-1:0] pos_o,         // Sensor position
    output wire             step_o,        // Motor step pulse
    output wire             dir_o          // Motor direction, 1 down
);
    reg         rs1_r;
    reg         rs2_r;
    wire        rst_n = rs2_r;
    reg  [3:0]  st_r;
    reg  [3:0]  st_nxt;
    reg  [POS_W-1:0] home_r;
    reg  [POS_W-1:0] tgt_r;
    reg  [SPD_W-1:0] intv_r;
    reg  [31:0] dwell_r;
    reg  [31:0] tick_r;
    reg  [31:0] ms_r;
    reg         tmr_fire_r;
    wire        ret_lvl;
    wire        ret_rise;
    wire        prf_rise;
    wire        at_tgt;
    wire [SPD_W-1:0] scan_intv;
    wire [31:0] dwell_cyc;

    // Two-flop reset release
    // Assertion acts at once; release waits two edges so no flop leaves reset metastable
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rs1_r <= 1'b0;
            rs2_r <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rs2_r <= rs1_r;
        end
    end

    sts_seq_filt #(.MIN_CYC(MIN_CYC), .CNT_W(32)) u_ret_filt (
        .clk_i  (clk_i),
        .rst_n  (rst_n),
        .req_i  (retreat_req_i),
        .level_o(ret_lvl),
        .rise_o (ret_rise)
    );

    sts_seq_filt #(.MIN_CYC(MIN_CYC), .CNT_W(32)) u_prf_filt (
        .clk_i  (clk_i),
        .rst_n  (rst_n),
        .req_i  (profile_req_i),
        .level_o(),
        .rise_o (prf_rise)
    );

    sts_seq_mover #(.POS_W(POS_W), .SPD_W(SPD_W)) u_mover (
        .clk_i   (clk_i),
        .rst_n   (rst_n),
        .run_i   (1'b1),
        .target_i(tgt_r),
        .intv_i  (intv_r),
        .pos_o   (pos_o),
        .step_o  (step_o),
        .dir_o   (dir_o),
        .at_o    (at_tgt)
    );

    // Divisor held at the interval width so the quotient keeps SPD_W bits
    localparam [SPD_W-1:0] PROF_MULT = `STS_PROF_MULT;

    // five-fold control speed, slowed by filter time
    assign scan_intv = (ctrl_intv_i / PROF_MULT) + {{(SPD_W-4){1'b0}}, filt_time_i};

    // Dwell length in cycles, default when zero
    assign dwell_cyc = (dwell_ms_i == 32'h0000_0000) ? DWELL_CYC[31:0]
                       : dwell_ms_i * TICK_CYC[31:0];

    // internal interval timer in ms ticks, auto mode only
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tick_r     <= 32'h0000_0000;
            ms_r       <= 32'h0000_0000;
            tmr_fire_r <= 1'b0;
        end else begin
            tmr_fire_r <= 1'b0;
            if (!(auto_mode_i && timer_en_i) || interval_ms_i == 32'h0000_0000) begin
                tick_r <= 32'h0000_0000;
                ms_r   <= 32'h0000_0000;
            end else if (tick_r >= TICK_CYC[31:0] - 32'h0000_0001) begin
                tick_r <= 32'h0000_0000;
                if (ms_r >= interval_ms_i - 32'h0000_0001) begin
                    ms_r       <= 32'h0000_0000;
                    tmr_fire_r <= 1'b1;
                end else begin
                    ms_r <= ms_r + 32'h0000_0001;
                end
            end else begin
                tick_r <= tick_r + 32'h0000_0001;
            end
        end
    end

    // Launch sources act only in automatic mode; a rise seen outside MEAS is
    // dropped rather than queued, so a late request cannot restart a sequence
    wire go_ret = auto_mode_i && (ret_rise || (tmr_fire_r && !timer_prof_i));
    wire go_prf = auto_mode_i && (prf_rise || (tmr_fire_r && timer_prof_i));

    // Next-state logic
    always @* begin
        st_nxt = st_r;
        case (st_r)
            `STS_ST_MEAS: begin
                // no excursion without request; retreat wins a tie
                if (go_ret)
                    st_nxt = `STS_ST_RET_OUT;
                else if (go_prf)
                    st_nxt = `STS_ST_PRF_UP;
            end
            `STS_ST_RET_OUT: begin
                if (at_tgt)
                    st_nxt = `STS_ST_RET_DWELL;
            end
            `STS_ST_RET_DWELL: begin
                if (dwell_r >= dwell_cyc - 32'h0000_0001)
                    st_nxt = ret_lvl ? `STS_ST_RET_HOLD : `STS_ST_RET_BACK;
            end
            `STS_ST_RET_HOLD: begin
                if (!ret_lvl)
                    st_nxt = `STS_ST_RET_BACK;
            end
            `STS_ST_RET_BACK: begin
                if (at_tgt)
                    st_nxt = `STS_ST_MEAS;
            end
            `STS_ST_PRF_UP: begin
                if (at_tgt)
                    st_nxt = `STS_ST_PRF_SCAN;
            end
            `STS_ST_PRF_SCAN: begin
                if (at_tgt)
                    st_nxt = `STS_ST_PRF_BACK;
            end
            `STS_ST_PRF_BACK: begin
                if (at_tgt)
                    st_nxt = `STS_ST_MEAS;
            end
            default: st_nxt = `STS_ST_MEAS;
        endcase
    end

    // State, home capture, dwell timer
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_r    <= `STS_ST_MEAS;
            home_r  <= {POS_W{1'b0}};
            dwell_r <= 32'h0000_0000;
        end else begin
            // edges outside MEAS are not looked at
            st_r <= st_nxt;
            // Home follows the sensor while measuring; the last MEAS cycle is the return point
            if (st_r == `STS_ST_MEAS)
                home_r <= pos_o;
            if (st_r == `STS_ST_RET_DWELL)
                dwell_r <= dwell_r + 32'h0000_0001;
            else
                dwell_r <= 32'h0000_0000;
        end
    end

    // Target and speed per state
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tgt_r  <= {POS_W{1'b0}};
            intv_r <= {SPD_W{1'b0}};
        end else begin
            case (st_nxt)
                `STS_ST_MEAS: begin
                    tgt_r  <= (st_r == `STS_ST_MEAS) ? meas_pos_i : home_r;
                    intv_r <= ctrl_intv_i;
                end
                `STS_ST_RET_OUT, `STS_ST_RET_DWELL, `STS_ST_RET_HOLD: begin
                    tgt_r  <= retreat_pos_i;
                    intv_r <= fast_intv_i;
                end
                `STS_ST_RET_BACK: begin
                    tgt_r  <= home_r;
                    intv_r <= fast_intv_i;
                end
                `STS_ST_PRF_UP: begin
                    tgt_r  <= top_pos_i;
                    intv_r <= fast_intv_i;
                end
                `STS_ST_PRF_SCAN: begin
                    tgt_r  <= bottom_pos_i;
                    intv_r <= scan_intv;
                end
                `STS_ST_PRF_BACK: begin
                    tgt_r  <= home_r;
                    intv_r <= fast_intv_i;
                end
                default: begin
                    tgt_r  <= home_r;
                    intv_r <= fast_intv_i;
                end
            endcase
        end
    end

    wire ret_excursion = (st_r == `STS_ST_RET_OUT) || (st_r == `STS_ST_RET_DWELL)
                         || (st_r == `STS_ST_RET_HOLD) || (st_r == `STS_ST_RET_BACK);
    wire prf_freeze    = (st_r == `STS_ST_PRF_UP) || (st_r == `STS_ST_PRF_BACK);

    // Output values and status
    // Freeze keys off the state itself, so values stop on the edge at which hold_o rises
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cur1_o      <= {OUT_W{1'b0}};
            cur2_o      <= {OUT_W{1'b0}};
            hold_o      <= 1'b0;
            busy_o      <= 1'b0;
            profiling_o <= 1'b0;
        end else begin
            busy_o      <= (st_r != `STS_ST_MEAS);
            profiling_o <= (st_r == `STS_ST_PRF_SCAN);
            hold_o      <= ret_excursion || prf_freeze;
            if (ret_excursion || prf_freeze) begin
                cur1_o <= cur1_o;
                cur2_o <= cur2_o;
            end else if (st_r == `STS_ST_PRF_SCAN) begin
                // depth on output one, solids optional
                cur1_o <= depth_i;
                if (solids_en_i)
                    cur2_o <= solids_i;
            end else begin
                cur1_o <= depth_i;
                cur2_o <= solids_i;
            end
        end
    end
endmodule

//--- dv/sts_seq_assertions.sv
// Port-level concurrent checks for the sensor travel sequencer
`timescale 1ns/1ps
module sts_seq_assertions #(
    parameter MIN_CYC = 8                 // Least request width, cycles
) (
    input wire        clk_i,              // Clock
    input wire        rstn_i,             // Reset, active low
    input wire        retreat_req_i,      // Retreat request
    input wire        profile_req_i,      // Profile request
    input wire        timer_en_i,         // Interval timer enable
    input wire [15:0] retreat_pos_i,      // Retreat height
    input wire [15:0] fast_intv_i,        // Fast step interval
    input wire [15:0] ctrl_intv_i,        // Control step interval
    input wire [3:0]  filt_time_i,        // Filter time setting
    input wire [15:0] depth_i,            // Live depth
    input wire [15:0] cur1_o,             // Output one
    input wire [15:0] cur2_o,             // Output two
    input wire        hold_o,             // Frozen flag
    input wire        busy_o,             // Excursion running
    input wire        profiling_o,        // Scan descent
    input wire [15:0] pos_o,              // Position
    input wire        step_o,             // Step pulse
    input wire        dir_o               // Direction, 1 down
);
    reg [7:0] hi_r;                       // Consecutive request-high samples
    reg [2:0] age_r;                      // Cycles since a full-width request
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Age of the last request that was long enough to be taken
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hi_r  <= 8'h00;
            age_r <= 3'h7;
        end else begin
            hi_r  <= (retreat_req_i | profile_req_i) ? ((hi_r != 8'hff) ? hi_r + 8'h01 : hi_r) : 8'h00;
            age_r <= (hi_r >= MIN_CYC) ? 3'h0 : ((age_r != 3'h7) ? age_r + 3'h1 : age_r);
        end
    end
    chk_busy_cause: assert property (
        $rose(busy_o) && !timer_en_i |-> age_r <= 3'h5) else $error("excursion began without a full-width request");
    chk_rest_quiet: assert property (
        !retreat_req_i && !profile_req_i && !timer_en_i && age_r == 3'h7 && !busy_o |=> !busy_o)
        else $error("excursion began with inputs quiet");
    chk_hold_frozen: assert property (
        hold_o && $past(hold_o) |-> $stable(cur1_o) && $stable(cur2_o)) else $error("outputs moved while frozen");
    chk_scan_flags: assert property (
        profiling_o |-> busy_o && !hold_o) else $error("scan flags inconsistent");
    chk_scan_depth: assert property (
        profiling_o && $past(profiling_o) |-> cur1_o == $past(depth_i)) else $error("depth not live during scan");
    chk_scan_down: assert property (
        profiling_o && step_o |-> dir_o) else $error("scan stepped upward");
    chk_scan_gap: assert property (
        profiling_o && step_o && (ctrl_intv_i / 16'h0005 + filt_time_i) >= 16'h0004
        |=> !(profiling_o && step_o) [*3]) else $error("scan steps too close");
    chk_fast_gap: assert property (
        hold_o && step_o && fast_intv_i > 16'h0001 |=> !(step_o && hold_o)) else $error("fast steps too close");
    chk_stay_up: assert property (
        hold_o && retreat_req_i && pos_o == retreat_pos_i && !profiling_o |=> pos_o == retreat_pos_i)
        else $error("left retreat height while requested");
endmodule
bind sts_seq sts_seq_assertions #(.MIN_CYC(MIN_CYC)) u_chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .retreat_req_i(retreat_req_i), .profile_req_i(profile_req_i),
    .timer_en_i(timer_en_i), .retreat_pos_i(retreat_pos_i), .fast_intv_i(fast_intv_i),
    .ctrl_intv_i(ctrl_intv_i), .filt_time_i(filt_time_i), .depth_i(depth_i), .cur1_o(cur1_o),
    .cur2_o(cur2_o), .hold_o(hold_o), .busy_o(busy_o), .profiling_o(profiling_o), .pos_o(pos_o),
    .step_o(step_o), .dir_o(dir_o));

//--- dv/sts_seq_plant.sv
// Plant controller model driving the two request lines
`timescale 1ns/1ps
module sts_seq_plant #(
    parameter DELAY_CYC = 2               // Control delay before asserting
) (
    input  wire        clk_i,             // Clock
    input  wire        go_i,              // Start one request pulse
    input  wire        sel_i,             // 1 profile, 0 retreat
    input  wire [31:0] len_i,             // Pulse width in cycles
    output wire        retreat_o,         // Retreat request, high level
    output wire        profile_o,         // Profile request, high level
    output wire        idle_o             // No pulse pending
);
    reg [31:0] wait_r = 32'h0000_0000;    // Delay left
    reg [31:0] left_r = 32'h0000_0000;    // High cycles left
    reg        sel_r  = 1'b0;             // Line chosen
    assign idle_o = (wait_r == 0) && (left_r == 0);
    // high level held for exactly the width asked
    assign retreat_o = (wait_r == 0) && (left_r != 0) && !sel_r;
    assign profile_o = (wait_r == 0) && (left_r != 0) && sel_r;
    // wait the control delay, then hold the line for the width
    always @(posedge clk_i) begin
        if (go_i && idle_o) begin
            wait_r <= DELAY_CYC;
            left_r <= len_i;
            sel_r  <= sel_i;
        end else if (wait_r != 0) begin
            wait_r <= wait_r - 1;
        end else if (left_r != 0) begin
            left_r <= left_r - 1;
        end
    end
endmodule

//--- dv/sts_seq_tb.sv
// Self-checking bench for the sensor travel sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module sts_seq_tb;
    localparam MIN = 8, DW = 20, TICK = 4, FAST = 3, CTRL = 10;
    reg clk_i = 0, rstn_i = 0, auto_mode_i = 1, timer_en_i = 0, timer_prof_i = 0, solids_en_i = 1;
    reg go = 0, sel = 0, seen = 0;
    reg [31:0] interval_ms_i = 0, dwell_ms_i = 0, len = 0;
    reg [3:0] filt_time_i = 2;
    reg [15:0] depth_i = 0, solids_i = 0, meas = 16'h001e, fast = FAST, ctrl = CTRL, lfsr = 16'h0025;
    wire retreat_req, profile_req, plant_idle, hold_o, busy_o, profiling_o, step_o, dir_o;
    wire [15:0] cur1_o, cur2_o, pos_o;
    integer miscompares = 0, cmp_count = 0, cyc = 0, gap = 0, last_gap = 0, n, i, d, sv;
    sts_seq #(.MIN_CYC(MIN), .DWELL_CYC(DW), .TICK_CYC(TICK)) dut (.clk_i(clk_i), .rstn_i(rstn_i),
        .retreat_req_i(retreat_req), .profile_req_i(profile_req), .auto_mode_i(auto_mode_i),
        .timer_en_i(timer_en_i), .timer_prof_i(timer_prof_i), .interval_ms_i(interval_ms_i),
        .dwell_ms_i(dwell_ms_i), .retreat_pos_i(16'h0005), .top_pos_i(16'h000a), .bottom_pos_i(16'h003c),
        .meas_pos_i(meas), .fast_intv_i(fast), .ctrl_intv_i(ctrl), .filt_time_i(filt_time_i),
        .depth_i(depth_i), .solids_i(solids_i), .solids_en_i(solids_en_i), .cur1_o(cur1_o), .cur2_o(cur2_o),
        .hold_o(hold_o), .busy_o(busy_o), .profiling_o(profiling_o), .pos_o(pos_o), .step_o(step_o),
        .dir_o(dir_o));
    sts_seq_plant plant (.clk_i(clk_i), .go_i(go), .sel_i(sel), .len_i(len), .retreat_o(retreat_req),
        .profile_o(profile_req), .idle_o(plant_idle));
    always #2 clk_i = ~clk_i;
    function [15:0] nxt(input [15:0] v);
        nxt = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task finish_test;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
            if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // Step spacing, scan seen and hang guard
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (profiling_o === 1'b1) seen = 1;
        if (step_o === 1'b1) begin
            last_gap = gap;
            gap = 1;
        end else gap = gap + 1;
        if (cyc == 40000) begin
            miscompares++;
            finish_test;
        end
    end
    // Advance cycles, feeding fresh live values
    task tick(input integer k);
        repeat (k) begin
            @(posedge clk_i);
            #1;
            lfsr = nxt(lfsr);
            depth_i = lfsr;
            solids_i = ~lfsr;
        end
    endtask
    task pulse(input s, input integer w);
        begin
            sel = s;
            len = w;
            go = 1;
            tick(1);
            go = 0;
        end
    endtask
    task wait_busy(input v);
        begin
            n = 0;
            while (busy_o !== v && n < 3000) begin tick(1); n++; end
            `CHK("busy", v, busy_o)
        end
    endtask
    task wait_pos(input [15:0] p);
        begin
            n = 0;
            while (pos_o !== p && n < 3000) begin tick(1); n++; end
            `CHK("position", p, pos_o)
        end
    endtask
    initial begin
        tick(3);
        rstn_i = 1;
        tick(4);
        wait_pos(meas);
        `CHK("idle", 1'b0, busy_o)
        pulse(0, MIN - 1);
        tick(MIN + 8);
        `CHK("short pulse", 1'b0, busy_o)
        $display("test quiet and short done");
        for (i = 0; i < 2; i++) begin
            meas = 16'h0014 + {12'h000, lfsr[3:0]};
            wait_pos(meas);
            dwell_ms_i = i * 3;
            d = i ? 3 * TICK : DW;
            pulse(0, MIN + lfsr[2:0]);
            wait_busy(1);
            sv = cur1_o;
            wait_pos(16'h0005);
            `CHK("out gap", FAST, last_gap)
            `CHK("hold", 1'b1, hold_o)
            `CHK("frozen", sv[15:0], cur1_o)
            tick(1);
            n = 0;
            while (step_o !== 1'b1 && n < 200) begin tick(1); n++; end
            `CHK("dwell", 1'b1, (n >= d && n <= d + FAST + 4))
            wait_pos(meas);
            `CHK("back gap", FAST, last_gap)
            wait_busy(0);
            $display("test retreat %0d done", i);
        end
        pulse(0, DW + 200);
        wait_pos(16'h0005);
        tick(DW + 60);
        `CHK("stay", 16'h0005, pos_o)
        wait_pos(meas);
        wait_busy(0);
        pulse(0, MIN);
        wait_busy(1);
        tick(4);
        pulse(1, MIN + 4);
        wait_busy(0);
        tick(MIN + 12);
        `CHK("ignored", 1'b0, busy_o)
        $display("test hold and ignore done");
        for (i = 0; i < 2; i++) begin
            filt_time_i = i ? 4'h5 : 4'h2;
            solids_en_i = i;
            pulse(1, MIN + 2);
            n = 0;
            while (profiling_o !== 1'b1 && n < 3000) begin tick(1); n++; end
            `CHK("scan top", 16'h000a, pos_o)
            sv = cur2_o;
            d = depth_i;
            tick(1);
            `CHK("scan depth", d[15:0], cur1_o)
            `CHK("scan solids", (i ? ~d[15:0] : sv[15:0]), cur2_o)
            while (profiling_o !== 1'b0 && n < 3000) begin tick(1); n++; end
            `CHK("scan bottom", 16'h003c, pos_o)
            `CHK("scan gap", CTRL / 5 + filt_time_i, last_gap)
            tick(5);
            `CHK("one scan", 1'b0, profiling_o)
            wait_pos(meas);
            `CHK("return gap", FAST, last_gap)
            wait_busy(0);
            $display("test profile %0d done", i);
        end
        for (i = 0; i < 2; i++) begin
            seen = 0;
            timer_prof_i = i;
            interval_ms_i = 20;
            timer_en_i = 1;
            wait_busy(1);
            // Keep the timer enabled through the edge at which busy is seen rising
            tick(1);
            timer_en_i = 0;
            wait_busy(0);
            `CHK("timer kind", i[0], seen)
        end
        auto_mode_i = 0;
        pulse(0, MIN + 4);
        tick(MIN + 12);
        `CHK("manual", 1'b0, busy_o)
        auto_mode_i = 1;
        $display("test timer and mode done");
        finish_test;
    end
endmodule
